// >>> rtl/fpirq_params.svh
// Register indices, field positions, reset values and counts of the FIFO port block
`ifndef FPIRQ_PARAMS_SVH
`define FPIRQ_PARAMS_SVH

// Register indices; byte address is four times the index
`define FPIRQ_IDX_COMMAND    10'h000
`define FPIRQ_IDX_FIFO_CFG   10'h002
`define FPIRQ_IDX_WATER      10'h003
`define FPIRQ_IDX_COUNT      10'h004
`define FPIRQ_IDX_FIFO_DATA  10'h005
`define FPIRQ_IDX_REQ_LOW    10'h006
`define FPIRQ_IDX_REQ_HIGH   10'h007
`define FPIRQ_IDX_EN_LOW     10'h008
`define FPIRQ_IDX_EN_HIGH    10'h009
`define FPIRQ_IDX_POINTER    10'h010
`define FPIRQ_IDX_WINDOW     10'h011

// Field positions
`define FPIRQ_SET_BIT        7
`define FPIRQ_CFG_DEPTH_SEL  7
`define FPIRQ_CFG_FLUSH      4
`define FPIRQ_CFG_WATER_EXT  2
`define FPIRQ_EN_INVERT      7
`define FPIRQ_EN_PUSH_PULL   7
`define FPIRQ_EN_PIN_DRIVE   6

// Reset values
`define FPIRQ_RST_BYTE       8'h00
`define FPIRQ_RST_COUNT      10'h000
`define FPIRQ_RST_CMD        5'h00
`define FPIRQ_RST_FLAGS_LOW  7'h00
`define FPIRQ_RST_FLAGS_HIGH 6'h00

// Depths and command codes
`define FPIRQ_DEPTH_SMALL    10'h0FF
`define FPIRQ_DEPTH_LARGE    10'h200
`define FPIRQ_CMD_IDLE       5'h00
`define FPIRQ_CMD_LAST_VALID 5'h13

// AXI responses
`define FPIRQ_RESP_OKAY      2'h0
`define FPIRQ_RESP_DECERR    2'h3

`endif

// >>> rtl/fpirq_pkg.sv
// Types shared by the FIFO port and request flag block
package fpirq_pkg;

  // Hardware events, all one-cycle pulses from logic on clk_sys
  typedef struct packed {
    logic       transmit_done;
    logic       receive_done;
    logic       fifo_write_fault;
    logic       fifo_overflow_fault;
    logic       protocol_fault;
    logic       no_data_fault;
    logic       integrity_fault;
    logic       start_of_frame;
    logic       subcarrier;
    logic       card_found;
    logic [4:0] timer_underflow;
  } fpirq_event_t;

  // Byte buffer side of the port
  typedef struct packed {
    logic       push;
    logic       pop;
    logic       flush;
    logic [7:0] wdata;
  } fpirq_fifo_ctl_t;

  typedef enum logic [2:0] {
    CMD_IDLE  = 3'b001,
    CMD_RUN   = 3'b010,
    CMD_ABORT = 3'b100
  } fpirq_cmd_state_t;

endpackage

// >>> rtl/fpirq_top.sv
// FIFO byte port, request flag registers and interrupt pin behind AXI4-Lite
`include "fpirq_params.svh"

module fpirq_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Byte buffer storage and datapath side
  output fpirq_pkg::fpirq_fifo_ctl_t     fifo_ctl,
  input  wire logic [7:0]                fifo_head_data,
  input  wire logic                      dp_push,
  input  wire logic                      dp_pop,
  // Command handshake with the datapath
  output logic [4:0]                     command_code,
  output logic                           command_start,
  input  wire logic                      command_finish,
  // Hardware events
  input  fpirq_pkg::fpirq_event_t        events,
  // Interrupt pin, open drain or push-pull
  output logic                           irq_pin_out,
  output logic                           irq_pin_oe
);
  import fpirq_pkg::*;

  // Write and read channel holding
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_held_reg;
  logic [7:0]        w_data_reg;
  logic              w_strb0_reg;
  logic              w_held_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [7:0]        rdata_reg;

  // Software registers
  logic [4:0]        cmd_reg;
  fpirq_cmd_state_t  cmd_state_reg;
  fpirq_cmd_state_t  cmd_state_next;
  logic [4:0]        cmd_next;
  logic              cmd_start_reg;
  logic              depth_sel_reg;
  logic              water_ext_reg;
  logic [7:0]        water_low_reg;
  logic [7:0]        en_low_reg;
  logic [7:0]        en_high_reg;
  logic [7:0]        pointer_reg;
  logic [9:0]        count_reg;
  logic [9:0]        count_next;
  logic [6:0]        flags_low_reg;
  logic [6:0]        flags_low_next;
  logic [5:0]        flags_high_reg;
  logic [5:0]        flags_high_next;
  logic              global_reg;
  logic              up_alert_prev_reg;
  logic              lo_alert_prev_reg;
  logic              pin_out_reg;
  logic              pin_oe_reg;
  logic              push_reg;
  logic              pop_reg;
  logic              flush_reg;

  // Channel handshakes
  assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};

  wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire rd_fire = s_axi_arvalid & ~rvalid_reg;

  // Address decode; the window reaches the register named by the pointer
  wire [9:0] w_idx      = aw_addr_reg[11:2];
  wire [9:0] r_idx      = s_axi_araddr[11:2];
  wire       w_via_win  = (w_idx == `FPIRQ_IDX_WINDOW);
  wire       r_via_win  = (r_idx == `FPIRQ_IDX_WINDOW);
  wire [9:0] w_eff      = w_via_win ? {2'h0, pointer_reg} : w_idx;
  wire [9:0] r_eff      = r_via_win ? {2'h0, pointer_reg} : r_idx;

  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == `FPIRQ_IDX_COMMAND)   || (idx == `FPIRQ_IDX_FIFO_CFG) ||
                 (idx == `FPIRQ_IDX_WATER)     || (idx == `FPIRQ_IDX_COUNT)    ||
                 (idx == `FPIRQ_IDX_FIFO_DATA) || (idx == `FPIRQ_IDX_REQ_LOW)  ||
                 (idx == `FPIRQ_IDX_REQ_HIGH)  || (idx == `FPIRQ_IDX_EN_LOW)   ||
                 (idx == `FPIRQ_IDX_EN_HIGH)   || (idx == `FPIRQ_IDX_POINTER);
  endfunction

  wire w_hit  = idx_mapped(w_eff);
  wire r_hit  = idx_mapped(r_eff);
  wire wr_ok  = wr_fire & w_hit & w_strb0_reg;
  wire rd_ok  = rd_fire & r_hit;

  wire wr_cmd      = wr_ok & (w_eff == `FPIRQ_IDX_COMMAND);
  wire wr_cfg      = wr_ok & (w_eff == `FPIRQ_IDX_FIFO_CFG);
  wire wr_water    = wr_ok & (w_eff == `FPIRQ_IDX_WATER);
  wire wr_fifo     = wr_ok & (w_eff == `FPIRQ_IDX_FIFO_DATA);
  wire wr_req_low  = wr_ok & (w_eff == `FPIRQ_IDX_REQ_LOW);
  wire wr_req_high = wr_ok & (w_eff == `FPIRQ_IDX_REQ_HIGH);
  wire wr_en_low   = wr_ok & (w_eff == `FPIRQ_IDX_EN_LOW);
  wire wr_en_high  = wr_ok & (w_eff == `FPIRQ_IDX_EN_HIGH);
  wire wr_pointer  = wr_ok & (w_eff == `FPIRQ_IDX_POINTER);
  wire rd_fifo     = rd_ok & (r_eff == `FPIRQ_IDX_FIFO_DATA);

  // Pointer steps after a window access, except on the FIFO port
  wire ptr_is_fifo = ({2'h0, pointer_reg} == `FPIRQ_IDX_FIFO_DATA);
  wire win_access  = (wr_fire & w_via_win) | (rd_fire & r_via_win);
  wire [7:0] pointer_next = wr_pointer ? w_data_reg :
                            (win_access & ~ptr_is_fifo) ? pointer_reg + 8'h01 :
                            pointer_reg;

  // Depth, water level and live alerts
  wire       large_mode = ~depth_sel_reg;
  wire [9:0] depth      = depth_sel_reg ? `FPIRQ_DEPTH_SMALL : `FPIRQ_DEPTH_LARGE;
  wire [9:0] water      = {1'b0, water_ext_reg & large_mode, water_low_reg};
  wire [9:0] free_space = depth - count_reg;
  wire       up_alert   = (free_space <= water);
  wire       lo_alert   = (count_reg <= water);
  wire       fifo_empty = (count_reg == `FPIRQ_RST_COUNT);
  wire       fifo_full  = (count_reg >= depth);

  // Byte count arithmetic; host and datapath may move bytes in one cycle
  wire host_push = wr_fifo & ~fifo_full;
  wire host_pop  = rd_fifo & ~fifo_empty;
  wire [10:0] add_n = {10'h000, host_push} + {10'h000, dp_push};
  wire [10:0] sub_n = {10'h000, host_pop} + {10'h000, dp_pop};
  wire [10:0] raw_up = {1'b0, count_reg} + add_n;
  wire [10:0] clamp_lo = (sub_n > raw_up) ? 11'h000 : raw_up - sub_n;
  wire        flush_req = wr_cfg & w_data_reg[`FPIRQ_CFG_FLUSH];
  assign count_next = flush_req ? `FPIRQ_RST_COUNT :
                      (clamp_lo > {1'b0, depth}) ? depth :
                      clamp_lo[9:0];

  // Command sequencing
  wire cmd_known  = (w_data_reg[4:0] <= `FPIRQ_CMD_LAST_VALID);
  wire cmd_is_idle = (w_data_reg[4:0] == `FPIRQ_CMD_IDLE);
  wire self_end   = ((cmd_state_reg == CMD_RUN) & command_finish & ~wr_cmd) |
                    (cmd_state_reg == CMD_ABORT);

  always_comb
  begin
    cmd_state_next = cmd_state_reg;
    cmd_next       = cmd_reg;
    case (cmd_state_reg)
      CMD_IDLE, CMD_RUN:
      begin
        if (wr_cmd)
        begin
          cmd_next = w_data_reg[4:0];
          if (cmd_is_idle)
            cmd_state_next = CMD_IDLE;
          else if (cmd_known)
            cmd_state_next = CMD_RUN;
          else
            cmd_state_next = CMD_ABORT;
        end
        else if (cmd_state_reg == CMD_RUN && command_finish)
        begin
          cmd_state_next = CMD_IDLE;
          cmd_next       = `FPIRQ_CMD_IDLE;
        end
      end
      CMD_ABORT:
      begin
        // Unknown code shows for one cycle, then falls back to idle
        cmd_state_next = CMD_IDLE;
        cmd_next       = `FPIRQ_CMD_IDLE;
      end
      default:
      begin
        cmd_state_next = CMD_IDLE;
        cmd_next       = `FPIRQ_CMD_IDLE;
      end
    endcase
  end

  // Hardware events per flag position
  wire [6:0] hw_low = {
    up_alert & ~up_alert_prev_reg,
    lo_alert & ~lo_alert_prev_reg,
    self_end,
    events.transmit_done,
    events.receive_done,
    events.fifo_write_fault | events.fifo_overflow_fault | events.protocol_fault |
      events.no_data_fault | events.integrity_fault,
    events.start_of_frame | events.subcarrier
  };
  wire [5:0] hw_high = {events.card_found, events.timer_underflow};

  // Set and clear masks from host writes
  wire       set_mode  = w_data_reg[`FPIRQ_SET_BIT];
  wire [6:0] low_sel   = wr_req_low ? w_data_reg[6:0] : 7'h00;
  wire [5:0] high_sel  = wr_req_high ? w_data_reg[5:0] : 6'h00;
  wire [6:0] low_set   = set_mode ? low_sel : 7'h00;
  wire [6:0] low_clr   = set_mode ? 7'h00 : low_sel;
  wire [5:0] high_set  = set_mode ? high_sel : 6'h00;
  wire [5:0] high_clr  = set_mode ? 6'h00 : high_sel;

  // Hardware set applied after the clear so an event is never lost
  assign flags_low_next  = (flags_low_reg & ~low_clr) | low_set | hw_low;
  assign flags_high_next = (flags_high_reg & ~high_clr) | high_set | hw_high;

  // Global request and pin
  wire global_next = |(flags_low_next & en_low_reg[6:0]) |
                     |(flags_high_next & en_high_reg[5:0]);
  wire pin_level   = global_next ^ en_low_reg[`FPIRQ_EN_INVERT];
  wire pin_drive   = en_high_reg[`FPIRQ_EN_PIN_DRIVE];
  // Open drain only pulls low; a high level is left to the pull-up
  wire pin_oe_next = pin_drive & (en_high_reg[`FPIRQ_EN_PUSH_PULL] | ~pin_level);

  // Read data selection
  wire [1:0] count_hi = large_mode ? count_reg[9:8] : 2'h0;
  wire [7:0] cfg_view = {depth_sel_reg, up_alert, lo_alert, 1'b0, 1'b0,
                         water_ext_reg, count_hi};
  wire [7:0] rd_value =
    (r_eff == `FPIRQ_IDX_COMMAND)   ? {3'h0, cmd_reg} :
    (r_eff == `FPIRQ_IDX_FIFO_CFG)  ? cfg_view :
    (r_eff == `FPIRQ_IDX_WATER)     ? water_low_reg :
    (r_eff == `FPIRQ_IDX_COUNT)     ? count_reg[7:0] :
    (r_eff == `FPIRQ_IDX_FIFO_DATA) ? (fifo_empty ? `FPIRQ_RST_BYTE : fifo_head_data) :
    (r_eff == `FPIRQ_IDX_REQ_LOW)   ? {1'b0, flags_low_reg} :
    (r_eff == `FPIRQ_IDX_REQ_HIGH)  ? {1'b0, global_reg, flags_high_reg} :
    (r_eff == `FPIRQ_IDX_EN_LOW)    ? en_low_reg :
    (r_eff == `FPIRQ_IDX_EN_HIGH)   ? en_high_reg :
    (r_eff == `FPIRQ_IDX_POINTER)   ? pointer_reg :
    `FPIRQ_RST_BYTE;

  assign fifo_ctl      = '{push: push_reg, pop: pop_reg, flush: flush_reg, wdata: w_data_reg};
  assign command_code  = cmd_reg;
  assign command_start = cmd_start_reg;
  assign irq_pin_out   = pin_out_reg;
  assign irq_pin_oe    = pin_oe_reg;

  // AXI channel state
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FPIRQ_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid & s_axi_wready)
        w_held_reg <= 1'b1;
      else if (wr_fire)
        w_held_reg <= 1'b0;
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= w_hit ? `FPIRQ_RESP_OKAY : `FPIRQ_RESP_DECERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Write data lane 0 only; upper lanes have no storage
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      w_data_reg  <= `FPIRQ_RST_BYTE;
      w_strb0_reg <= 1'b0;
    end
    else if (s_axi_wvalid & s_axi_wready)
    begin
      w_data_reg  <= s_axi_wdata[7:0];
      w_strb0_reg <= s_axi_wstrb[0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `FPIRQ_RESP_OKAY;
      rdata_reg  <= `FPIRQ_RST_BYTE;
    end
    else if (rd_fire)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= r_hit ? `FPIRQ_RESP_OKAY : `FPIRQ_RESP_DECERR;
      rdata_reg  <= r_hit ? rd_value : `FPIRQ_RST_BYTE;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // Configuration and enables
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      depth_sel_reg <= 1'b0;
      water_ext_reg <= 1'b0;
      water_low_reg <= `FPIRQ_RST_BYTE;
      en_low_reg    <= `FPIRQ_RST_BYTE;
      en_high_reg   <= `FPIRQ_RST_BYTE;
      pointer_reg   <= `FPIRQ_RST_BYTE;
    end
    else
    begin
      if (wr_cfg)
      begin
        depth_sel_reg <= w_data_reg[`FPIRQ_CFG_DEPTH_SEL];
        water_ext_reg <= w_data_reg[`FPIRQ_CFG_WATER_EXT];
      end
      if (wr_water)
        water_low_reg <= w_data_reg;
      if (wr_en_low)
        en_low_reg <= w_data_reg;
      if (wr_en_high)
        en_high_reg <= w_data_reg;
      pointer_reg <= pointer_next;
    end
  end

  // Count, flags and pin
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      count_reg         <= `FPIRQ_RST_COUNT;
      flags_low_reg     <= `FPIRQ_RST_FLAGS_LOW;
      flags_high_reg    <= `FPIRQ_RST_FLAGS_HIGH;
      global_reg        <= 1'b0;
      // Held high so the alert already true after reset is not an event
      up_alert_prev_reg <= 1'b1;
      lo_alert_prev_reg <= 1'b1;
      pin_out_reg       <= 1'b0;
      pin_oe_reg        <= 1'b0;
    end
    else
    begin
      count_reg         <= count_next;
      flags_low_reg     <= flags_low_next;
      flags_high_reg    <= flags_high_next;
      global_reg        <= global_next;
      up_alert_prev_reg <= up_alert;
      lo_alert_prev_reg <= lo_alert;
      pin_out_reg       <= pin_level;
      pin_oe_reg        <= pin_oe_next;
    end
  end

  // Command register and buffer strobes
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmd_state_reg <= CMD_IDLE;
      cmd_reg       <= `FPIRQ_RST_CMD;
      cmd_start_reg <= 1'b0;
      push_reg      <= 1'b0;
      pop_reg       <= 1'b0;
      flush_reg     <= 1'b0;
    end
    else
    begin
      cmd_state_reg <= cmd_state_next;
      cmd_reg       <= cmd_next;
      cmd_start_reg <= wr_cmd & ~cmd_is_idle & cmd_known;
      push_reg      <= host_push;
      pop_reg       <= host_pop;
      flush_reg     <= flush_req;
    end
  end

endmodule // fpirq_top

// >>> verif/fifo_port_and_irq_flags_tb.sv
// Self-checking bench for the FIFO port and request flag block
module fifo_port_and_irq_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fpirq_pkg::*;
  logic            clk_sys, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic            s_axi_rready, dp_push, dp_pop, command_start, command_finish;
  logic            irq_pin_out, irq_pin_oe;
  logic [11:0]     s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp, rsp, brsp;
  logic [7:0]      fifo_head_data, rd, w, flo, fhi;
  logic [4:0]      command_code;
  fpirq_fifo_ctl_t fifo_ctl;
  fpirq_event_t    events;
  logic [7:0]      bytes[$];
  int              err_total, samples_checked, cycles, n;

  fpirq_top u_fpirq_top (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fifo_ctl, .fifo_head_data, .dp_push, .dp_pop,
    .command_code, .command_start, .command_finish, .events, .irq_pin_out, .irq_pin_oe);
  fpirq_fifo_model u_fpirq_fifo_model (.clk_sys, .reset, .fifo_ctl, .fifo_head_data);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Ceiling well above the roughly 1600 cycles the sequence needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      final_report;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok, w_ok, b_ok;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      // Ready and valid read settled, ahead of the edge that takes them
      @(negedge clk_sys);
      aw_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = s_axi_bvalid;
      brsp = s_axi_bresp;
      @(posedge clk_sys);
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end while (!b_ok);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge clk_sys);
      ar_ok = s_axi_arvalid & s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      r = s_axi_rresp;
      @(posedge clk_sys);
      if (ar_ok)
        s_axi_arvalid <= 1'b0;
    end while (!r_ok);
    s_axi_rready <= 1'b0;
  endtask

  // Data and response compared together, OKAY expected
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    rd_reg(a, rd, rsp);
    check({22'h000000, rsp, rd}, {24'h000000, e});
  endtask

  task automatic pulse_ev(input int k);
    @(posedge clk_sys);
    events <= fpirq_event_t'(15'h0001 << k);
    @(posedge clk_sys);
    events <= '0;
  endtask

  function automatic logic [7:0] upd(input logic [7:0] old, input logic [7:0] v, input logic [7:0] m);
    return v[7] ? (old | (v & m)) : (old & ~(v & m));
  endfunction

  // Event bit k (struct order, timer 0 at bit 0) to expected low and high flags
  function automatic logic [15:0] ev_exp(input int k);
    logic [7:0] lo;
    lo = (k == 14) ? 8'h08 : (k == 13) ? 8'h04 : (k >= 8) ? 8'h02 : (k >= 6) ? 8'h01 : 8'h00;
    return {lo, (k == 5) ? 8'h20 : (k < 5) ? 8'(8'h01 << k) : 8'h00};
  endfunction

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {dp_push, dp_pop, command_finish} = 3'h0;
    events = '0;
    reset = 1'b1;
    void'($urandom(32'hAF0A));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    rchk(12'h010, 8'h00);
    rchk(12'h018, 8'h00);
    rd_reg(12'h03C, rd, rsp);
    check(32'(rsp), 32'h00000003);
    wr(12'h010, 8'h5A);
    check(32'(brsp), 32'h00000000);
    rchk(12'h010, 8'h00);
    s_axi_wstrb <= 4'hE;
    wr(12'h00C, 8'h77);
    s_axi_wstrb <= 4'hF;
    check(32'(brsp), 32'h00000000);
    rchk(12'h00C, 8'h00);
    wr(12'h03C, 8'h11);
    check(32'(brsp), 32'h00000003);
    n = $urandom_range(8, 3);
    for (int i = 0; i < n; i++)
    begin
      bytes.push_back(8'($urandom));
      wr(12'h014, bytes[i]);
    end
    rchk(12'h010, 8'(n));
    wr(12'h040, 8'h05);
    for (int i = 0; i < n; i++)
      rchk(12'h044, bytes.pop_front());
    rchk(12'h040, 8'h05);
    rchk(12'h010, 8'h00);
    rchk(12'h014, 8'h00);
    rchk(12'h010, 8'h00);
    wr(12'h040, 8'h03);
    rd_reg(12'h044, rd, rsp);
    rchk(12'h040, 8'h04);
    wr(12'h018, 8'h7F);
    wr(12'h01C, 8'h7F);
    {flo, fhi} = 16'h0000;
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 8'hFF : 8'($urandom);
      wr(12'h018, w);
      flo = upd(flo, w, 8'h7F);
      rchk(12'h018, flo);
      wr(12'h01C, w);
      fhi = upd(fhi, w, 8'h3F);
      rchk(12'h01C, fhi);
    end
    for (int k = 0; k < 15; k++)
    begin
      wr(12'h018, 8'h7F);
      wr(12'h01C, 8'h7F);
      pulse_ev(k);
      {flo, fhi} = ev_exp(k);
      rchk(12'h018, flo);
      rchk(12'h01C, fhi);
    end
    wr(12'h018, 8'h7F);
    wr(12'h01C, 8'h7F);
    wr(12'h020, 8'h08);
    wr(12'h024, 8'hC0);
    pulse_ev(13);
    rchk(12'h01C, 8'h00);
    check({irq_pin_oe, irq_pin_out}, 32'h2);
    pulse_ev(14);
    rchk(12'h01C, 8'h40);
    check({irq_pin_oe, irq_pin_out}, 32'h3);
    wr(12'h020, 8'h88);
    rchk(12'h020, 8'h88);
    check({irq_pin_oe, irq_pin_out}, 32'h2);
    wr(12'h024, 8'h40);
    rchk(12'h024, 8'h40);
    check({irq_pin_oe, irq_pin_out}, 32'h2);
    wr(12'h020, 8'h08);
    rchk(12'h020, 8'h08);
    check({irq_pin_oe, irq_pin_out}, 32'h1);
    wr(12'h024, 8'h00);
    rchk(12'h024, 8'h00);
    check(irq_pin_oe, 32'h0);
    wr(12'h020, 8'h00);
    wr(12'h018, 8'h7F);
    wr(12'h000, 8'h01);
    @(posedge clk_sys);
    command_finish <= 1'b1;
    @(posedge clk_sys);
    command_finish <= 1'b0;
    rchk(12'h000, 8'h00);
    rchk(12'h018, 8'h10);
    wr(12'h018, 8'h7F);
    wr(12'h000, 8'h1F);
    rchk(12'h000, 8'h00);
    rchk(12'h018, 8'h10);
    wr(12'h018, 8'h7F);
    wr(12'h000, 8'h05);
    wr(12'h000, 8'h00);
    rchk(12'h018, 8'h00);
    wr(12'h00C, 8'h02);
    wr(12'h008, 8'h80);
    wr(12'h018, 8'h7F);
    for (int i = 0; i < 256; i++)
    begin
      bytes.push_back(8'($urandom));
      wr(12'h014, bytes[i]);
      if (i == 252)
        rchk(12'h018, 8'h40);
    end
    rchk(12'h010, 8'hFF);
    for (int i = 0; i < 3; i++)
      rchk(12'h014, bytes.pop_front());
    rchk(12'h018, 8'h40);
    wr(12'h008, 8'h90);
    rchk(12'h018, 8'h60);
    for (int i = 0; i < 3; i++)
      wr(12'h014, 8'($urandom));
    rchk(12'h018, 8'h60);
    final_report;
  end
endmodule // fifo_port_and_irq_flags_tb

// >>> verif/fpirq_fifo_model.sv
// Behavioural byte buffer standing behind the FIFO port
module fpirq_fifo_model
  import fpirq_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       reset,
  input fpirq_fifo_ctl_t fifo_ctl,
  output logic [7:0]     fifo_head_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store[$];
  logic [7:0] last_byte;

  // Empty buffer shows the inverse of its last byte, so stale data cannot pass
  always @(posedge clk_sys)
  begin
    if (reset || fifo_ctl.flush)
      store.delete();
    else
    begin
      if (fifo_ctl.pop && store.size() > 0)
        last_byte = store.pop_front();
      if (fifo_ctl.push)
        store.push_back(fifo_ctl.wdata);
    end
    fifo_head_data <= (store.size() > 0) ? store[0] : ~last_byte;
  end
endmodule // fpirq_fifo_model

// >>> verif/fpirq_top_sva.sv
// Checker for the bus handshakes, port strobes and command field of the FIFO port block
`include "fpirq_params.svh"

module fpirq_top_sva
  import fpirq_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input fpirq_fifo_ctl_t  fifo_ctl,
  input wire logic [4:0]  command_code,
  input wire logic        command_start,
  input wire logic        command_finish
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence wr_answered;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence rd_answered;
    s_axi_rvalid && s_axi_rready;
  endsequence

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  bvalid_release_a: assert property (wr_answered |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not released after handshake");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  rvalid_release_a: assert property (rd_answered |=> !s_axi_rvalid)
    else $error("read data not released after handshake");
  rd_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000 && !s_axi_arready)
    else $error("read word carries more than one byte");
  push_pulse_a: assert property (fifo_ctl.push |=> !fifo_ctl.push)
    else $error("push strobe longer than one cycle");
  pop_pulse_a: assert property (fifo_ctl.pop |=> !fifo_ctl.pop)
    else $error("pop strobe longer than one cycle");
  idle_start_a: assert property (command_start |-> command_code != `FPIRQ_CMD_IDLE)
    else $error("idle command started");
  unknown_cmd_a: assert property (command_code > `FPIRQ_CMD_LAST_VALID |=> command_code == 5'h00)
    else $error("unknown command not returned to idle");
  finish_idle_a: assert property (command_finish && command_code != 5'h00 &&
    command_code <= `FPIRQ_CMD_LAST_VALID |=> command_code == 5'h00)
    else $error("finished command not returned to idle");
endmodule // fpirq_top_sva

bind fpirq_top fpirq_top_sva u_fpirq_top_sva (.clk_sys, .reset, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .fifo_ctl, .command_code, .command_start, .command_finish);
